//--- hw/imw_pkg.sv
// What this block does
// [RULE_01] lower port bit4 high starts initialization
// [RULE_02] word one bit3 selects edge or level
// [RULE_03] level request dropped early yields line 7
// [RULE_04] peripheral drops level request before end-of-service
// [RULE_05] software keeps bit1 zero for cascade
// [RULE_06] word one bit0 flags word four needed
// [RULE_07] reserved bits 7:5 zero, bit2 ignored
// [RULE_08] word two bits 7:3 drive ad 7:3
// [RULE_09] ad 2:0 carries winning request level
// [RULE_10] software writes zero to word two 2:0
// [RULE_11] word three bit n marks slave present
// [RULE_12] software sets word three bit 2
// [RULE_13] software clears other word three bits
// [RULE_14] words two and three share upper port
// [RULE_15] next upper writes load two, three, four
// [RULE_16] word one resets count and priority state
// [RULE_17] slave output feeds master request line 2
// [RULE_18] skip word three/four unless selected
package imw_pkg;
  localparam logic [9:0] ADDR_LOWER = 10'h020; // lower port
  localparam logic [9:0] ADDR_UPPER = 10'h021; // upper port
  localparam int BIT_INIT = 4;
  localparam int BIT_LEVEL = 3;
  localparam int BIT_SINGLE = 1;
  localparam int BIT_NEED_FOUR = 0;
  localparam logic [7:0] RST_WORD = 8'h00; // reset of every stored word
  localparam logic [2:0] LINE_SPURIOUS = 3'h7; // request_line_7
  localparam logic [2:0] SLAVE_ADDR_INIT = 3'h7;
  localparam logic [2:0] CASCADE_LINE = 3'h2; // request_line_2
  // sequence position
  typedef enum logic [3:0] {
    IMW_READY = 4'h1,
    IMW_WAIT_TWO = 4'h2,
    IMW_WAIT_THREE = 4'h4,
    IMW_WAIT_FOUR = 4'h8
  } imw_seq_e;
endpackage

//--- hw/imw_master_init.sv
`timescale 1ns/1ps
module imw_master_init (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic io_wr, // one-cycle write strobe
  input wire logic [9:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic ack_data, // acknowledge data phase
  input wire logic [7:0] irq_req, // master request lines
  input wire logic slave_irq, // slave_irq_unit output
  input wire logic [2:0] win_level, // from priority resolution
  input wire logic win_valid, // a request still wins
  output logic [7:0] ad_out, // vector on ad
  output logic ad_oe, // high while driving ad
  output logic [7:0] req_to_resolve, // requests after cascade
  output logic level_mode,
  output logic single_mode,
  output logic need_four,
  output logic [7:0] slave_map,
  output logic [7:0] init_word_four,
  output logic init_busy, // sequence in progress
  output logic init_start, // pulse: word one seen
  output logic ocw_wr, // pulse: operation_cmd_word write
  output logic prio_reset, // pulse: fixed prio, clear mask, etc
  output logic [2:0] slave_addr
);
  // whole state in one struct
  typedef struct packed {
    imw_pkg::imw_seq_e seq;
    logic [7:0] word_one;
    logic [4:0] vec_base;
    logic [7:0] word_three;
    logic [7:0] word_four;
    logic [7:0] ad;
    logic ad_en;
    logic start;
    logic operation_cmd_word;
    logic [2:0] saddr;
  } imw_state_s;
  imw_state_s st;
  imw_state_s next_st;
  logic wr_low; // write to lower port
  logic wr_up; // write to upper port
  assign wr_low = io_wr && (io_addr == imw_pkg::ADDR_LOWER);
  assign wr_up = io_wr && (io_addr == imw_pkg::ADDR_UPPER);

  // next-state logic
  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    next_st.operation_cmd_word = 1'b0;
    if (wr_low && io_wdata[imw_pkg::BIT_INIT]) begin // RULE_01
      next_st.word_one = io_wdata; // bits 7:5 and 2 stored but unused RULE_07
      next_st.seq = imw_pkg::IMW_WAIT_TWO; // RULE_16
      next_st.start = 1'b1; // RULE_16
      next_st.saddr = imw_pkg::SLAVE_ADDR_INIT; // RULE_16
    end else if (wr_low) begin
      next_st.operation_cmd_word = 1'b1; // operation word, also ends the sequence RULE_01
      next_st.seq = imw_pkg::IMW_READY;
    end else if (wr_up) begin
      case (st.seq)
        imw_pkg::IMW_WAIT_TWO: begin
          next_st.vec_base = io_wdata[7:3]; // RULE_08 RULE_14 RULE_15
          // jump past words not selected RULE_18
          if (!st.word_one[imw_pkg::BIT_SINGLE]) begin
            next_st.seq = imw_pkg::IMW_WAIT_THREE;
          end else if (st.word_one[imw_pkg::BIT_NEED_FOUR]) begin
            next_st.seq = imw_pkg::IMW_WAIT_FOUR;
          end else begin
            next_st.seq = imw_pkg::IMW_READY;
          end
        end
        imw_pkg::IMW_WAIT_THREE: begin
          next_st.word_three = io_wdata; // RULE_11 RULE_14 RULE_15
          if (st.word_one[imw_pkg::BIT_NEED_FOUR]) begin // RULE_06 RULE_18
            next_st.seq = imw_pkg::IMW_WAIT_FOUR;
          end else begin
            next_st.seq = imw_pkg::IMW_READY;
          end
        end
        imw_pkg::IMW_WAIT_FOUR: begin
          next_st.word_four = io_wdata; // RULE_15
          next_st.seq = imw_pkg::IMW_READY;
        end
        default: begin
          next_st.operation_cmd_word = 1'b1; // mask word when idle
        end
      endcase
    end
    // acknowledge vector: base plus winning level
    next_st.ad_en = ack_data;
    if (ack_data) begin
      // dropped level request with nothing pending gives line 7 RULE_03
      // the host still expects a full vector, so line 7 fills the low bits
      next_st.ad = {st.vec_base,
                    win_valid ? win_level : imw_pkg::LINE_SPURIOUS}; // RULE_08 RULE_09
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st.seq <= imw_pkg::IMW_READY;
      st.word_one <= imw_pkg::RST_WORD;
      st.vec_base <= imw_pkg::RST_WORD[7:3];
      st.word_three <= imw_pkg::RST_WORD;
      st.word_four <= imw_pkg::RST_WORD;
      st.ad <= imw_pkg::RST_WORD;
      st.ad_en <= 1'b0;
      st.start <= 1'b0;
      st.operation_cmd_word <= 1'b0;
      st.saddr <= imw_pkg::SLAVE_ADDR_INIT;
    end else begin
      st <= next_st;
    end
  end

  // slave output replaces master line 2 RULE_17
  always_comb begin
    req_to_resolve = irq_req;
    req_to_resolve[imw_pkg::CASCADE_LINE] = slave_irq;
  end

  assign ad_out = st.ad;
  assign ad_oe = st.ad_en;
  assign level_mode = st.word_one[imw_pkg::BIT_LEVEL]; // RULE_02
  assign single_mode = st.word_one[imw_pkg::BIT_SINGLE];
  assign need_four = st.word_one[imw_pkg::BIT_NEED_FOUR]; // RULE_06
  assign slave_map = st.word_three; // RULE_11
  assign init_word_four = st.word_four;
  assign init_busy = (st.seq != imw_pkg::IMW_READY);
  assign init_start = st.start;
  assign prio_reset = st.start; // RULE_16
  assign ocw_wr = st.operation_cmd_word;
  assign slave_addr = st.saddr;

  // checks on the init sequence and the vector
  // lower-port write with the init bit set
  sequence s_init_write;
    wr_low && io_wdata[imw_pkg::BIT_INIT];
  endsequence
  // lower-port write with the init bit clear: an operation word
  sequence s_op_write;
    wr_low && !io_wdata[imw_pkg::BIT_INIT];
  endsequence
  // upper-port write while word two is awaited
  sequence s_up_in_two;
    wr_up && st.seq == imw_pkg::IMW_WAIT_TWO;
  endsequence
  // upper-port write while word three is awaited
  sequence s_up_in_three;
    wr_up && st.seq == imw_pkg::IMW_WAIT_THREE;
  endsequence
  // upper-port write while word four is awaited
  sequence s_up_in_four;
    wr_up && st.seq == imw_pkg::IMW_WAIT_FOUR;
  endsequence

  // word one opens the sequence and restores the slave address
  a_init_starts: assert property (@(posedge clk_sys) disable iff (rst) // RULE_01
    s_init_write |=> init_start && init_busy && slave_addr == 3'h7)
    else $error("init word did not start sequence");
  // base bits reach the vector one cycle after the acknowledge
  a_vec_base: assert property (@(posedge clk_sys) disable iff (rst) // RULE_08
    ack_data |=> ad_oe && ad_out[7:3] == $past(st.vec_base))
    else $error("vector base not driven");
  // winning level fills the low bits
  a_vec_level: assert property (@(posedge clk_sys) disable iff (rst) // RULE_09
    ack_data && win_valid |=> ad_out[2:0] == $past(win_level))
    else $error("vector level wrong");
  // nothing left to win gives line 7
  a_spurious_seven: assert property (@(posedge clk_sys) disable iff (rst) // RULE_03
    ack_data && !win_valid |=> ad_out[2:0] == 3'h7)
    else $error("dropped request not line 7");
  // trigger mode follows bit 3 of word one
  a_level_mode: assert property (@(posedge clk_sys) disable iff (rst) // RULE_02
    s_init_write |=> level_mode == $past(io_wdata[3]))
    else $error("trigger mode not stored");
  // word four flag follows bit 0 of word one
  a_need_four: assert property (@(posedge clk_sys) disable iff (rst) // RULE_06
    s_init_write |=> need_four == $past(io_wdata[0]))
    else $error("word four flag not stored");
  // first upper write after word one loads the base
  a_word_two: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
    s_up_in_two |=> st.vec_base == $past(io_wdata[7:3]))
    else $error("second word not loaded");
  // slave output takes line 2, low lines pass through
  a_cascade_feed: assert property (@(posedge clk_sys) disable iff (rst) // RULE_17
    req_to_resolve[2] == slave_irq && req_to_resolve[1:0] == irq_req[1:0])
    else $error("slave not on line 2");
  // upper write in the third slot loads the slave map
  a_word_three: assert property (@(posedge clk_sys) disable iff (rst) // RULE_11
    s_up_in_three |=> slave_map == $past(io_wdata))
    else $error("slave map not loaded");
  // single mode without word four ends after word two
  a_single_skip: assert property (@(posedge clk_sys) disable iff (rst) // RULE_18
    wr_up && st.seq == imw_pkg::IMW_WAIT_TWO && single_mode && !need_four |=> !init_busy)
    else $error("single mode did not end");
  // an operation word always leaves the init sequence
  a_op_ends: assert property (@(posedge clk_sys) disable iff (rst) // RULE_01
    s_op_write |=> ocw_wr && !init_busy && !init_start)
    else $error("operation word did not end sequence");
  // word four lands and closes the sequence
  a_word_four: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
    s_up_in_four |=> init_word_four == $past(io_wdata) && !init_busy)
    else $error("fourth word not loaded");
  // cascade with word four wanted waits for it after word three
  a_four_wait: assert property (@(posedge clk_sys) disable iff (rst) // RULE_18
    wr_up && st.seq == imw_pkg::IMW_WAIT_THREE && need_four
      |=> st.seq == imw_pkg::IMW_WAIT_FOUR)
    else $error("fourth word not awaited");
  // without word four the sequence ends at word three
  a_three_done: assert property (@(posedge clk_sys) disable iff (rst) // RULE_18
    wr_up && st.seq == imw_pkg::IMW_WAIT_THREE && !need_four |=> !init_busy)
    else $error("sequence did not end after third word");
  // the start pulse only ever follows an init word
  a_start_cause: assert property (@(posedge clk_sys) disable iff (rst) // RULE_16
    init_start |-> $past(wr_low && io_wdata[imw_pkg::BIT_INIT]))
    else $error("start pulse without init word");
  // the vector is driven only in the cycle after an acknowledge
  a_ad_idle: assert property (@(posedge clk_sys) disable iff (rst) // RULE_08
    !ack_data |=> !ad_oe)
    else $error("vector driven outside acknowledge");
  // lines above the cascade pass straight through
  a_cascade_rest: assert property (@(posedge clk_sys) disable iff (rst) // RULE_17
    req_to_resolve[7:3] == irq_req[7:3])
    else $error("master lines altered by cascade");
endmodule

//--- bench/imw_host_model.sv
`timescale 1ns/1ps
// host side: issues io writes and acknowledge data phases
module imw_host_model (
  input wire logic clk_sys,
  output logic io_wr,
  output logic [9:0] io_addr,
  output logic [7:0] io_wdata,
  output logic ack_data,
  output logic [2:0] win_level,
  output logic win_valid
);
  // idle bus from time zero
  initial begin
    io_wr = 1'h0;
    io_addr = 10'h000;
    io_wdata = 8'h00;
    ack_data = 1'h0;
    win_level = 3'h0;
    win_valid = 1'h0;
  end
  // one write, held until the edge that takes it; word one keeps
  // reserved bits and the single bit clear, as software must
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_wr <= 1'h1;
    io_addr <= a;
    io_wdata <= (a == 10'h020 && d[4]) ? (d & 8'h1D) : d;
    @(posedge clk_sys);
    io_wr <= 1'h0;
    // released lines show no stale value
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask
  // one acknowledge data phase; valid low models a dropped request
  task automatic ack(input logic [2:0] lv, input logic v);
    @(posedge clk_sys);
    ack_data <= 1'h1;
    win_level <= lv;
    win_valid <= v;
    @(posedge clk_sys);
    ack_data <= 1'h0;
    win_level <= ~lv;
    win_valid <= ~v;
  endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
// drives init word sequences and acknowledge phases, checks outputs
module tb;
  logic clk_sys, rst, slave_irq, io_wr, ack_data, win_valid, ad_oe;
  logic level_mode, single_mode, need_four, init_busy, init_start, ocw_wr, prio_reset;
  logic [7:0] irq_req, io_wdata, ad_out, req_to_resolve, slave_map, init_word_four;
  logic [9:0] io_addr;
  logic [2:0] win_level, slave_addr;
  int err_count = 0;
  int check_count = 0;
  localparam logic [9:0] LO = imw_pkg::ADDR_LOWER;
  localparam logic [9:0] UP = imw_pkg::ADDR_UPPER;
  imw_host_model host (.clk_sys(clk_sys), .io_wr(io_wr), .io_addr(io_addr),
    .io_wdata(io_wdata), .ack_data(ack_data), .win_level(win_level), .win_valid(win_valid));
  imw_master_init DUT (.clk_sys(clk_sys), .rst(rst), .io_wr(io_wr), .io_addr(io_addr),
    .io_wdata(io_wdata), .ack_data(ack_data), .irq_req(irq_req), .slave_irq(slave_irq),
    .win_level(win_level), .win_valid(win_valid), .ad_out(ad_out), .ad_oe(ad_oe),
    .req_to_resolve(req_to_resolve), .level_mode(level_mode), .single_mode(single_mode),
    .need_four(need_four), .slave_map(slave_map), .init_word_four(init_word_four),
    .init_busy(init_busy), .init_start(init_start), .ocw_wr(ocw_wr),
    .prio_reset(prio_reset), .slave_addr(slave_addr));
  // 50 ns clock
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  // compare and count; case inequality so unknowns fail
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict in one place
  task automatic final_report();
    $display("mismatches %0d, checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (2000) @(posedge clk_sys);
    err_count++;
    final_report();
  end
  // main sequence
  initial begin
    rst = 1'h1;
    irq_req = 8'hF0;
    slave_irq = 1'h1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    #1;
    chk({5'h00, slave_addr}, 8'h07);
    chk(req_to_resolve, 8'hF4);
    // level mode, word four wanted
    host.wr(LO, 8'h19);
    #1;
    chk({init_start, prio_reset, 6'h00}, 8'hC0);
    chk({level_mode, single_mode, need_four, init_busy, 4'h0}, 8'hB0);
    host.wr(UP, 8'hA8);
    host.wr(UP, 8'h04);
    #1;
    chk(slave_map, 8'h04);
    host.wr(UP, 8'h5A);
    #1;
    chk(init_word_four, 8'h5A);
    chk({7'h00, init_busy}, 8'h00);
    host.ack(3'h3, 1'h1);
    #1;
    chk({ad_oe, 7'h00}, 8'h80);
    chk(ad_out, 8'hAB);
    // vector drive stands for one cycle only
    @(posedge clk_sys);
    #1;
    chk({ad_oe, 7'h00}, 8'h00);
    host.ack(3'h5, 1'h0);
    #1;
    chk(ad_out, 8'hAF);
    // edge mode, no word four: sequence ends after word three
    host.wr(LO, 8'h10);
    host.wr(UP, 8'h50);
    host.wr(UP, 8'h04);
    #1;
    chk({level_mode, need_four, init_busy, ocw_wr, 4'h0}, 8'h00);
    host.wr(UP, 8'h33);
    #1;
    chk({ocw_wr, init_busy, 6'h00}, 8'h80);
    chk(slave_map, 8'h04);
    host.ack(3'h0, 1'h1);
    #1;
    chk(ad_out, 8'h50);
    // lower write with bit4 low aborts the sequence
    host.wr(LO, 8'h11);
    host.wr(LO, 8'h08);
    #1;
    chk({ocw_wr, init_busy, init_start, 5'h00}, 8'h80);
    @(posedge clk_sys);
    irq_req <= 8'h0F;
    slave_irq <= 1'h0;
    @(posedge clk_sys);
    #1;
    chk(req_to_resolve, 8'h0B);
    final_report();
  end
endmodule
